// File: design/rha_core.sv
// holding-register read and single-register write interpreter.
// assumes a same-clock framer delivering bytes and an end-of-frame
// pulse, a serializer with valid/ready, and a parameter store that
// answers a read request with par_rvalid one or more cycles later.
//
// Overview of operation
// - read to station zero gets no answer
// - identifier: group high byte, item 0..99 low
// - only table group codes reach the store
// - register address is base plus group*256 plus item
// - read length limited to 1..50 words
// - unused parameter reads as zero, no error
// - words past group's last item read zero
// - read reply: station, code, 2n count, data, check
// - words high byte first, ascending addresses
// - broadcast single write executes without reply
// - write carries two data bytes, stored as given
// - write reply echoes query fields exactly
// - frame ends in check; length from message code
// - station 0..247, zero means broadcast
`default_nettype none

module rha_core (
    // clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset_n,
    // configuration
    input  wire logic [7:0]         own_addr,
    // received bytes from the framer
    input  wire logic               rx_valid,
    input  wire logic [7:0]         rx_byte,
    input  wire logic               rx_frame_end,
    // response bytes to the serializer
    output logic                    tx_valid,
    output logic [7:0]              tx_byte,
    input  wire logic               tx_ready,
    // parameter store
    output rha_pkg::rha_par_req_s   par_req,
    output logic                    par_rd,
    output logic                    par_wr,
    input  wire logic               par_rvalid,
    input  wire logic               par_used,
    input  wire logic [15:0]        par_rdata
);

    typedef enum logic [3:0] {
        ST_RX, ST_ECHO, ST_HDR, ST_FETCH, ST_WAIT,
        ST_DHI, ST_DLO, ST_CRCL, ST_CRCH
    } rha_state_e;

    logic             rst_meta_r;
    logic             rst_n_r;
    rha_state_e       st_r;
    rha_state_e       st_adv;
    logic [3:0]       cnt_r;
    logic [15:0]      crc_r;
    logic [7:0]       q_r [0:7];
    logic [2:0]       idx_r;
    logic [7:0]       words_r;
    logic [7:0]       item_r;
    logic [15:0]      word_r;
    logic [7:0]       tx_nxt;
    logic             addr_ok;
    logic             accept;
    logic             words_ok;
    logic             frame_eval;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // own address outside 1..247 answers nothing but broadcasts
    assign addr_ok = (q_r[0] == rha_pkg::BCAST_ADDR) ||
                     (q_r[0] == own_addr && own_addr != rha_pkg::BCAST_ADDR
                      && own_addr <= rha_pkg::MAX_STATION);
    // running check over the whole frame leaves zero when intact
    assign accept = (cnt_r == rha_pkg::fc_len(q_r[1])) &&
                    (cnt_r != rha_pkg::NO_LEN) &&
                    (crc_r == 16'h0000) && addr_ok;
    assign words_ok = (q_r[4] == 8'h00) && (q_r[5] != 8'h00) &&
                      (q_r[5] <= rha_pkg::MAX_WORDS);
    assign frame_eval = (st_r == ST_RX) && rx_frame_end;

    // byte to present and state to take once it is accepted
    always_comb begin
        tx_nxt = 8'h00;
        st_adv = ST_RX;
        case (st_r)
            ST_ECHO: begin
                tx_nxt = q_r[idx_r];
                st_adv = (idx_r == rha_pkg::ECHO_LAST) ? ST_CRCL : ST_ECHO;
            end
            ST_HDR: begin
                case (idx_r)
                    3'h0:    tx_nxt = q_r[0];
                    3'h1:    tx_nxt = rha_pkg::FC_READ;
                    default: tx_nxt = {words_r[6:0], 1'b0};
                endcase
                st_adv = (idx_r == rha_pkg::HDR_LAST) ? ST_FETCH : ST_HDR;
            end
            ST_DHI: begin
                tx_nxt = word_r[15:8];
                st_adv = ST_DLO;
            end
            ST_DLO: begin
                tx_nxt = word_r[7:0];
                st_adv = (words_r == 8'h01) ? ST_CRCL : ST_FETCH;
            end
            ST_CRCL: begin
                tx_nxt = crc_r[7:0];
                st_adv = ST_CRCH;
            end
            ST_CRCH: begin
                tx_nxt = crc_r[15:8];
                st_adv = ST_RX;
            end
            default: begin
                tx_nxt = 8'h00;
                st_adv = ST_RX;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            st_r     <= ST_RX;
            cnt_r    <= 4'h0;
            crc_r    <= rha_pkg::CRC_INIT;
            idx_r    <= 3'h0;
            words_r  <= 8'h00;
            item_r   <= 8'h00;
            word_r   <= 16'h0000;
            tx_valid <= 1'b0;
            tx_byte  <= 8'h00;
            par_rd   <= 1'b0;
            par_wr   <= 1'b0;
            par_req  <= '0;
            for (int i = 0; i < 8; i++) begin
                q_r[i] <= 8'h00;
            end
        end else begin
            par_rd <= 1'b0;
            par_wr <= 1'b0;
            case (st_r)
                ST_RX: begin
                    if (rx_frame_end) begin
                        cnt_r <= 4'h0;
                        crc_r <= rha_pkg::CRC_INIT;
                        if (accept && q_r[1] == rha_pkg::FC_WRITE) begin
                            par_req.addr  <= rha_pkg::reg_addr(q_r[2], q_r[3]);
                            par_req.group <= q_r[2];
                            par_req.item  <= q_r[3];
                            par_req.wdata <= {q_r[4], q_r[5]};
                            // unknown group or item is dropped silently
                            par_wr <= rha_pkg::group_known(q_r[2]) &&
                                      q_r[3] <= rha_pkg::MAX_ITEM;
                            if (q_r[0] != rha_pkg::BCAST_ADDR) begin
                                st_r  <= ST_ECHO;
                                idx_r <= 3'h0;
                            end
                        end else if (accept && words_ok &&
                                     q_r[1] == rha_pkg::FC_READ &&
                                     q_r[0] != rha_pkg::BCAST_ADDR) begin
                            words_r <= q_r[5];
                            item_r  <= q_r[3];
                            idx_r   <= 3'h0;
                            st_r    <= ST_HDR;
                        end
                    end else if (rx_valid) begin
                        if (cnt_r < rha_pkg::QUERY_LEN) begin
                            q_r[cnt_r[2:0]] <= rx_byte;
                        end
                        // saturate so an overlong frame never matches
                        if (cnt_r != 4'hF) begin
                            cnt_r <= cnt_r + 4'h1;
                        end
                        crc_r <= rha_pkg::crc_step(crc_r, rx_byte);
                    end
                end
                ST_FETCH: begin
                    if (rha_pkg::group_known(q_r[2]) &&
                        item_r <= rha_pkg::MAX_ITEM) begin
                        par_req.addr  <= rha_pkg::reg_addr(q_r[2], item_r);
                        par_req.group <= q_r[2];
                        par_req.item  <= item_r;
                        par_rd        <= 1'b1;
                        st_r          <= ST_WAIT;
                    end else begin
                        word_r <= 16'h0000;
                        st_r   <= ST_DHI;
                    end
                end
                ST_WAIT: begin
                    if (par_rvalid) begin
                        word_r <= par_used ? par_rdata : 16'h0000;
                        st_r   <= ST_DHI;
                    end
                end
                ST_ECHO, ST_HDR, ST_DHI, ST_DLO, ST_CRCL, ST_CRCH: begin
                    if (!tx_valid) begin
                        tx_valid <= 1'b1;
                        tx_byte  <= tx_nxt;
                    end else if (tx_ready) begin
                        tx_valid <= 1'b0;
                        st_r     <= st_adv;
                        idx_r    <= idx_r + 3'h1;
                        // check bytes themselves stay out of the sum
                        if (st_r != ST_CRCL && st_r != ST_CRCH) begin
                            crc_r <= rha_pkg::crc_step(crc_r, tx_byte);
                        end
                        if (st_r == ST_DLO) begin
                            words_r <= words_r - 8'h01;
                            item_r  <= item_r + 8'h01;
                        end
                        if (st_r == ST_CRCH) begin
                            crc_r <= rha_pkg::CRC_INIT;
                            cnt_r <= 4'h0;
                        end
                    end
                end
                default: st_r <= ST_RX;
            endcase
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n_r);

    a_read_bcast_silent: assert property (
        frame_eval && q_r[1] == rha_pkg::FC_READ &&
        q_r[0] == rha_pkg::BCAST_ADDR |=> st_r == ST_RX && !tx_valid)
        else $error("broadcast read produced a response");
    a_item_range: assert property (
        par_rd || par_wr |-> par_req.item <= rha_pkg::MAX_ITEM)
        else $error("store access with item above 99");
    a_group_known: assert property (
        par_rd |-> rha_pkg::group_known(par_req.group))
        else $error("store read with unmapped group");
    a_reg_address: assert property (
        par_rd || par_wr |-> par_req.addr ==
        17'(40000 + 256 * par_req.group + par_req.item))
        else $error("register address mapping wrong");
    a_word_limit: assert property (
        st_r == ST_HDR |-> words_r >= 8'h01 && words_r <= 8'h32)
        else $error("read length outside 1..50");
    a_unused_zero: assert property (
        st_r == ST_WAIT && par_rvalid && !par_used |=>
        st_r == ST_DHI && word_r == 16'h0000)
        else $error("unused parameter not read as zero");
    a_group_edge: assert property (
        st_r == ST_FETCH && item_r > 8'h63 |=>
        st_r == ST_DHI && word_r == 16'h0000 && !par_rd)
        else $error("word past group end not zero");
    a_byte_count: assert property (
        st_r == ST_HDR && idx_r == 3'h2 && tx_valid |->
        tx_byte == 8'(2 * words_r))
        else $error("byte count not twice word count");
    a_high_first: assert property (
        st_r == ST_DHI && tx_valid && tx_ready |=> st_r == ST_DLO
        ##1 tx_valid && tx_byte == $past(word_r[7:0], 2))
        else $error("low byte did not follow high byte");
    a_write_bcast: assert property (
        frame_eval && accept && q_r[1] == rha_pkg::FC_WRITE &&
        q_r[0] == rha_pkg::BCAST_ADDR |=> st_r == ST_RX ##1 !tx_valid)
        else $error("broadcast write answered");
    a_write_data: assert property (
        frame_eval && accept && q_r[1] == rha_pkg::FC_WRITE |=>
        par_req.wdata == {$past(q_r[4]), $past(q_r[5])})
        else $error("write data not taken high then low");
    a_echo_start: assert property (
        frame_eval && accept && q_r[1] == rha_pkg::FC_WRITE &&
        q_r[0] != rha_pkg::BCAST_ADDR |=> ##1 tx_valid &&
        tx_byte == q_r[0])
        else $error("write echo does not open with station");
    a_foreign_drop: assert property (
        frame_eval && q_r[0] != own_addr &&
        q_r[0] != rha_pkg::BCAST_ADDR |=> st_r == ST_RX && !par_wr)
        else $error("foreign station query acted upon");
    a_check_gate: assert property (
        frame_eval && crc_r != 16'h0000 |=>
        st_r == ST_RX && !par_wr && !par_rd)
        else $error("bad check frame acted upon");

    // the last word's count has already been spent by its low data byte
    c_read_reply: cover property (st_r == ST_CRCH && tx_valid && tx_ready
                                  && words_r == 8'h00);
    c_write_echo: cover property (st_r == ST_ECHO && idx_r == 3'h5);
    c_bcast_write: cover property (frame_eval && accept &&
                                   q_r[0] == rha_pkg::BCAST_ADDR);
    c_zero_fill: cover property (st_r == ST_FETCH && item_r > 8'h63);

endmodule

`default_nettype wire

// File: design/rha_pkg.sv
// shared constants, carrier types and helper functions for the
// holding-register access interpreter.
// assumes a byte-level framer on the same clock in front of the block.
`default_nettype none

package rha_pkg;

    // message codes and station addresses
    localparam logic [7:0]  FC_READ     = 8'h03;
    localparam logic [7:0]  FC_WRITE    = 8'h06;
    localparam logic [7:0]  BCAST_ADDR  = 8'h00;
    localparam logic [7:0]  MAX_STATION = 8'hF7;

    // query layout: addr, code, group, item, hi, lo, check lo, check hi
    localparam logic [3:0]  QUERY_LEN   = 4'h8;
    localparam logic [3:0]  NO_LEN      = 4'h0;
    localparam logic [2:0]  ECHO_LAST   = 3'h5;
    localparam logic [2:0]  HDR_LAST    = 3'h2;

    // parameter space limits
    localparam logic [7:0]  MAX_ITEM    = 8'h63;
    localparam logic [7:0]  MAX_WORDS   = 8'h32;
    localparam logic [16:0] REG_BASE    = 17'h09C40;

    // check field
    localparam logic [15:0] CRC_INIT    = 16'hFFFF;
    localparam logic [15:0] CRC_POLY    = 16'hA001;

    typedef struct packed {
        logic [16:0] addr;
        logic [7:0]  group;
        logic [7:0]  item;
        logic [15:0] wdata;
    } rha_par_req_s;

    // one byte of the reflected check, low bit first
    function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                             input logic [7:0]  b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    // group codes that the conversion table assigns to a letter group
    function automatic logic group_known(input logic [7:0] code);
        case (code)
            8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
            8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E, 8'h0F, 8'h10,
            8'h11, 8'h12, 8'h13, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A,
            8'h1B, 8'h1F, 8'h27, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34,
            8'h35, 8'hCE, 8'hCF: return 1'b1;
            default:             return 1'b0;
        endcase
    endfunction

    // base plus group times 256 plus item
    function automatic logic [16:0] reg_addr(input logic [7:0] group,
                                             input logic [7:0] item);
        return REG_BASE + {1'b0, group, item};
    endfunction

    // whole query length implied by the message code
    function automatic logic [3:0] fc_len(input logic [7:0] fc);
        return (fc == FC_READ || fc == FC_WRITE) ? QUERY_LEN : NO_LEN;
    endfunction

endpackage

`default_nettype wire

// File: test/rha_host.sv
// host model: sends whole query frames and collects the reply bytes.
// assumes the interpreter's byte ports, all on core_clk.
`default_nettype none

module rha_host (
    // clock
    input  wire logic       core_clk,
    // query bytes toward the interpreter
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            rx_frame_end,
    // reply bytes from the interpreter
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       slow;
    logic [7:0] got [$];

    initial begin
        rx_valid     = 1'b0;
        rx_byte      = 8'h00;
        rx_frame_end = 1'b0;
        tx_ready     = 1'b0;
        slow         = 1'b0;
    end

    // a slow host stalls most bytes, so each reply byte must be held
    always @(negedge core_clk) begin
        tx_ready <= slow ? ($urandom % 3 == 0) : 1'b1;
    end

    always @(posedge core_clk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_byte);
        end
    end

    // whole frame, check last; the released byte line shows garbage
    task automatic send(input logic [7:0] f [$]);
        foreach (f[i]) begin
            @(negedge core_clk);
            rx_valid = 1'b1;
            rx_byte  = f[i];
        end
        @(negedge core_clk);
        rx_valid     = 1'b0;
        rx_byte      = ~rx_byte;
        rx_frame_end = 1'b1;
        @(negedge core_clk);
        rx_frame_end = 1'b0;
    endtask
endmodule

`default_nettype wire

// File: test/tb.sv
// self-checking bench: host model in front, parameter store behind,
// each reply predicted from integers and compared byte by byte.
// assumes rha_pkg, rha_core and rha_host are compiled before it.
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  core_clk;
    logic                  reset_n;
    logic [7:0]            own_addr;
    logic                  rx_valid;
    logic [7:0]            rx_byte;
    logic                  rx_frame_end;
    logic                  tx_valid;
    logic [7:0]            tx_byte;
    logic                  tx_ready;
    rha_pkg::rha_par_req_s par_req;
    logic                  par_rd;
    logic                  par_wr;
    logic                  par_rvalid;
    logic                  par_used;
    logic [15:0]           par_rdata;
    int                    error_cnt;
    int                    n_compared;
    int                    rd_a;
    int                    pick;
    logic [15:0]           mem [int];
    logic                  exp_wr;
    logic [16:0]           exp_wa;
    logic [15:0]           exp_wd;
    logic [7:0]            exp_wg;
    logic [7:0]            exp_wi;

    rha_core uut (
        .core_clk(core_clk), .reset_n(reset_n), .own_addr(own_addr),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_frame_end(rx_frame_end),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
        .par_req(par_req), .par_rd(par_rd), .par_wr(par_wr),
        .par_rvalid(par_rvalid), .par_used(par_used), .par_rdata(par_rdata)
    );

    rha_host host (
        .core_clk(core_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .rx_frame_end(rx_frame_end), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready)
    );

    function automatic logic [15:0] crc16(input logic [7:0] b [$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction

    function automatic bit known(input int g);
        return g <= 11 || (g >= 13 && g <= 19) || (g >= 22 && g <= 27)
            || g == 31 || g == 39 || (g >= 48 && g <= 53)
            || g == 206 || g == 207;
    endfunction

    // store contents: some addresses unused, the rest seeded by address
    function automatic bit used(input int a);
        return a % 5 != 2;
    endfunction

    function automatic logic [15:0] val(input int a);
        return mem.exists(a) ? mem[a] : 16'(a) ^ 16'h5A5A;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    always @(posedge core_clk) begin
        if (par_rd) begin
            rd_a = int'(par_req.addr);
            repeat (1 + $urandom % 3) @(negedge core_clk);
            par_rvalid = 1'b1;
            par_used   = used(rd_a);
            par_rdata  = val(rd_a);
            @(negedge core_clk);
            par_rvalid = 1'b0;
            par_rdata  = ~par_rdata;
        end
    end

    always @(posedge core_clk) begin
        if (par_wr) begin
            chk("write wanted", 32'h1, 32'(exp_wr));
            chk("write addr", 32'(exp_wa), 32'(par_req.addr));
            chk("write data", 32'(exp_wd), 32'(par_req.wdata));
            chk("write group", 32'(exp_wg), 32'(par_req.group));
            chk("write item", 32'(exp_wi), 32'(par_req.item));
            mem[int'(par_req.addr)] = par_req.wdata;
            exp_wr = 1'b0;
        end
    end

    task automatic q(input logic [7:0] st, fc, g, it, hi, lo, input bit bad);
        logic [7:0]  f [$];
        logic [7:0]  e [$];
        logic [15:0] c;
        int          n;
        int          a;
        int          w;
        int          t;
        bit          me;
        f = {st, fc, g, it, hi, lo};
        // only a station address of 1..247 can be our own
        me = st == own_addr && own_addr != 8'h00 && own_addr <= 8'hF7;
        c = crc16(f);
        f.push_back(c[7:0] ^ {7'h00, bad});
        f.push_back(c[15:8]);
        n = {hi, lo};
        if (!bad && fc == 8'h03 && me && n >= 1 && n <= 50) begin
            e = {st, fc, 8'(2 * n)};
            for (int i = 0; i < n; i++) begin
                a = 40000 + g * 256 + it + i;
                w = (known(g) && it + i <= 99 && used(a)) ? val(a) : 0;
                e.push_back(w[15:8]);
                e.push_back(w[7:0]);
            end
        end
        if (!bad && fc == 8'h06 && (me || st == 8'h00)) begin
            exp_wr = known(g) && it <= 99;
            exp_wg = g;
            exp_wi = it;
            exp_wa = 17'(40000 + g * 256 + it);
            exp_wd = {hi, lo};
            if (st != 8'h00) e = f[0:5];
        end
        if (e.size() > 0) begin
            c = crc16(e);
            e.push_back(c[7:0]);
            e.push_back(c[15:8]);
        end
        host.got.delete();
        host.send(f);
        t = 0;
        while (host.got.size() < e.size() && t < 3000) begin
            @(negedge core_clk);
            t++;
        end
        repeat (30) @(negedge core_clk);
        chk("reply length", 32'(e.size()), 32'(host.got.size()));
        foreach (e[i]) begin
            if (i < host.got.size()) begin
                chk("reply byte", 32'(e[i]), 32'(host.got[i]));
            end
        end
        chk("write pending", 32'h0, 32'(exp_wr));
        exp_wr = 1'b0;
    endtask

    task automatic tdone(input string nm);
        $display("test %s done, mismatches %0d", nm, error_cnt);
    endtask

    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // roughly ninety thousand cycles, far past the longest test mix
    initial begin
        #720000;
        error_cnt++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        reset_n    = 1'b0;
        own_addr   = 8'h2A;
        par_rvalid = 1'b0;
        par_used   = 1'b0;
        par_rdata  = 16'h0000;
        exp_wr     = 1'b0;
        error_cnt  = 0;
        n_compared = 0;
        void'($urandom(32'h26FC0625));
        repeat (20) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (5) @(negedge core_clk);
        q(8'h2A, 8'h03, 8'h01, 8'h0F, 8'h00, 8'h01, 1'b0);
        host.slow = 1'b1;
        q(8'h2A, 8'h03, 8'h00, 8'h3C, 8'h00, 8'h32, 1'b0);
        q(8'h2A, 8'h03, 8'h0E, 8'h5F, 8'h00, 8'h08, 1'b0);
        q(8'h2A, 8'h03, 8'h0C, 8'h00, 8'h00, 8'h04, 1'b0);
        tdone("reads");
        q(8'h2A, 8'h03, 8'h0D, 8'h00, 8'h00, 8'h33, 1'b0);
        q(8'h2A, 8'h03, 8'h0D, 8'h00, 8'h00, 8'h00, 1'b0);
        q(8'h2A, 8'h03, 8'h0D, 8'h00, 8'h01, 8'h01, 1'b0);
        q(8'h00, 8'h03, 8'h0D, 8'h00, 8'h00, 8'h02, 1'b0);
        q(8'h2B, 8'h03, 8'h0D, 8'h00, 8'h00, 8'h02, 1'b0);
        q(8'h2B, 8'h06, 8'h0D, 8'h01, 8'h12, 8'h34, 1'b0);
        q(8'h2A, 8'h03, 8'h0D, 8'h00, 8'h00, 8'h02, 1'b1);
        q(8'h2A, 8'h06, 8'h0D, 8'h01, 8'h12, 8'h34, 1'b1);
        q(8'h2A, 8'h10, 8'h0D, 8'h01, 8'h00, 8'h01, 1'b0);
        tdone("silent");
        q(8'h2A, 8'h06, 8'h0D, 8'h3C, 8'($urandom), 8'($urandom), 1'b0);
        q(8'h2A, 8'h03, 8'h0D, 8'h3A, 8'h00, 8'h04, 1'b0);
        q(8'h00, 8'h06, 8'h0E, 8'h05, 8'($urandom), 8'($urandom), 1'b0);
        q(8'h2A, 8'h03, 8'h0E, 8'h05, 8'h00, 8'h01, 1'b0);
        q(8'h2A, 8'h06, 8'h01, 8'h64, 8'hAB, 8'hCD, 1'b0);
        own_addr = 8'hF7;
        q(8'hF7, 8'h03, 8'hCF, 8'h62, 8'h00, 8'h03, 1'b0);
        own_addr = 8'hF8;
        q(8'hF8, 8'h03, 8'h01, 8'h00, 8'h00, 8'h01, 1'b0);
        q(8'hF8, 8'h06, 8'h01, 8'h02, 8'h00, 8'h07, 1'b0);
        own_addr = 8'h2A;
        tdone("writes");
        for (int k = 0; k < 24; k++) begin
            pick = $urandom % 4;
            q(pick == 0 ? 8'h00 : pick == 1 ? 8'h33 : own_addr,
              pick[0] ? 8'h03 : 8'h06, 8'($urandom % 56),
              8'($urandom % 104), 8'h00, 8'($urandom % 53), 1'b0);
        end
        tdone("random");
        end_of_test();
    end
endmodule

`default_nettype wire
